// ---- sim/rsc_host.sv ----
// Purpose: host model sending commands, taking replies
// Assumes: cmd is called just after a rising edge
// Notes:   slow adds random reply stalls
`timescale 1ns/1ps
`default_nettype none
module rsc_host (
   input  wire logic       clk_i,      // bench clock
   input  wire logic       ce_i,       // block enable
   input  wire logic [7:0] tx_byte_i,  // reply byte
   input  wire logic       tx_valid_i, // reply offered
   output logic      [7:0] rx_byte_o,  // command byte
   output logic            rx_valid_o, // command strobe
   output logic            tx_ready_o  // reply taken
);
   bit         slow = 0; // back-pressure on
   logic [7:0] got[$];   // replies taken
   initial begin
      rx_byte_o = 8'h00;
      rx_valid_o = 0;
      tx_ready_o = 1;
   end
   // only edges where the block advances count as taken
   always @(posedge clk_i) begin
      if (tx_valid_i === 1'b1 && tx_ready_o && ce_i === 1'b1) got.push_back(tx_byte_i);
      #1 tx_ready_o <= slow ? 1'($urandom_range(1)) : 1'b1;
   end
   // host turns a two-character hex field into its decimal value
   function automatic int hex2dec(input logic [7:0] hi, lo);
      int h, l;
      h = (hi >= 8'h41) ? int'(hi) - 32'h37 : int'(hi) - 32'h30;
      l = (lo >= 8'h41) ? int'(lo) - 32'h37 : int'(lo) - 32'h30;
      return h * 16 + l;
   endfunction
   // bytes back to back, held over frozen edges
   task automatic cmd(input logic [7:0] b0, b1, b2);
      logic [7:0] b[3];
      b = '{b0, b1, b2};
      foreach (b[i]) begin
         rx_byte_o = b[i];
         rx_valid_o = 1;
         do @(posedge clk_i); while (ce_i !== 1'b1);
         #1;
      end
      rx_valid_o = 0;
      rx_byte_o = ~rx_byte_o; // no stale byte left on the line
   endtask
endmodule // rsc_host
`default_nettype wire

// ---- sim/rsc_service_properties.sv ----
// Purpose: port assertions for rsc_service
// Assumes: one clock, sync active-high reset
// Notes:   bound below the module
`timescale 1ns/1ps
`default_nettype none
module rsc_service_chk
   import rsc_pkg::*;
(
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic       ce_i,
   input wire logic       tx_ready_i,
   input wire logic [7:0] tx_byte_o,
   input wire logic       tx_valid_o,
   input wire logic       ready_o,
   input wire logic       defaults_o,
   input wire logic       int_reset_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic [15:0] n_hi, next_n_hi; // enabled edges spent in self-test
   always_comb next_n_hi = int_reset_o ? n_hi + 16'(ce_i) : 16'h0000;
   always_ff @(posedge clk_i) n_hi <= rst_i ? 16'h0000 : next_n_hi;
   AST_TEST_BUSY: assert property (int_reset_o |-> !ready_o)
      else $error("ready high in self-test");
   AST_TEST_LEN: assert property ($fell(int_reset_o) |->
      n_hi >= RSC_TEST_CYC - 16'h0002 && n_hi <= RSC_TEST_CYC + 16'h0002)
      else $error("self-test length off");
   AST_READY_BACK: assert property ($fell(int_reset_o) |-> ##[0:2] ready_o)
      else $error("ready not back after self-test");
   AST_TEST_AFTER_OK: assert property ($rose(int_reset_o) |-> !tx_valid_o)
      else $error("reply pending at reset");
   AST_DEF_PULSE: assert property (defaults_o && ce_i |=> !defaults_o)
      else $error("defaults pulse too long");
   AST_DEF_ACK: assert property (defaults_o |-> ##[1:4] tx_valid_o && tx_byte_o == RSC_CH_O)
      else $error("no ack after defaults");
   AST_TX_HOLD: assert property (tx_valid_o && !(tx_ready_i && ce_i) |=>
      tx_valid_o && $stable(tx_byte_o))
      else $error("reply byte not held");
   AST_TX_GAP: assert property (tx_valid_o && tx_ready_i && ce_i |=> !tx_valid_o)
      else $error("no gap after taken byte");
   AST_TX_BUSY: assert property (tx_valid_o |-> !ready_o)
      else $error("ready high while replying");
   COV_DEF: cover property (defaults_o);
   COV_TEST: cover property ($rose(int_reset_o));
   COV_STALL: cover property (tx_valid_o && !tx_ready_i);
endmodule // rsc_service_chk
bind rsc_service rsc_service_chk u_chk (.clk_i, .rst_i, .ce_i, .tx_ready_i, .tx_byte_o,
   .tx_valid_o, .ready_o, .defaults_o, .int_reset_o);
`default_nettype wire

// ---- sim/testbench.sv ----
// Purpose: self-checking bench for rsc_service
// Assumes: host model drives the byte stream
// Notes:   expected replies built from the command table
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import rsc_pkg::*;
   logic clk_i, rst_i, ce_i, frz, rdy, rx_v, tx_valid_o, ready_o, defaults_o, int_reset_o;
   logic [7:0] rx_b, tx_byte_o;
   rsc_sig_t   sig_i;
   int         n_fail, n_compared, n_def, n_tst;
   logic [7:0] exp_q[$];
   logic [23:0] bad[4] = '{24'h000002, 24'h002001, 24'h802002, 24'h800001};
   rsc_host host (.clk_i, .ce_i, .tx_byte_i(tx_byte_o), .tx_valid_i(tx_valid_o),
      .rx_byte_o(rx_b), .rx_valid_o(rx_v), .tx_ready_o(rdy));
   rsc_service uut (.clk_i, .rst_i, .ce_i, .rx_byte_i(rx_b), .rx_valid_i(rx_v), .sig_i,
      .tx_ready_i(rdy), .tx_byte_o, .tx_valid_o, .ready_o, .defaults_o, .int_reset_o);
   initial begin
      clk_i = 0;
      forever #50 clk_i = ~clk_i;
   end
   // random freezes while frz is set
   always @(posedge clk_i) #1 ce_i <= !(frz && $urandom_range(3) == 0);
   always @(posedge clk_i) begin
      n_def += (defaults_o === 1'b1 && ce_i === 1'b1);
      n_tst += (int_reset_o === 1'b1);
   end
   task automatic chk_b(input logic [7:0] g, e);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected at %0t: byte %h not %h", $time, g, e);
      end
   endtask
   task automatic chk_n(input logic [31:0] g, e);
      n_compared++;
      if (g !== e) begin
         n_fail++;
         $display("unexpected at %0t: count %0d not %0d", $time, g, e);
      end
   endtask
   task automatic close_out;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   function automatic logic [7:0] hx(input logic [3:0] n);
      return (n < 4'hA) ? 8'h30 + 8'(n) : 8'h37 + 8'(n);
   endfunction
   // one command, wait for idle, compare reply
   task automatic run(input string nm, input logic [7:0] b0, b1, b2, input bit busy);
      int k;
      host.cmd(b0, b1, b2);
      if (busy) chk_b({7'h00, ready_o}, 8'h00);
      k = 0;
      while (ready_o !== 1'b1 && k < 1500) begin
         @(posedge clk_i);
         #1 k++;
      end
      chk_n({31'h0, ready_o === 1'b1}, 32'h1);
      chk_n(host.got.size(), exp_q.size());
      foreach (exp_q[i]) chk_b(host.got[i], exp_q[i]);
      if (nm == "signal" || nm == "after reset") begin
         chk_n(host.hex2dec(host.got[0], host.got[1]), sig_i.env);
         chk_n(host.hex2dec(host.got[2], host.got[3]), sig_i.data);
      end
      host.got.delete();
      exp_q.delete();
      $display("test %s done", nm);
   endtask
   initial begin
      {rst_i, ce_i, frz, sig_i, n_fail, n_compared, n_def, n_tst} = '0;
      rst_i = 1;
      ce_i = 1;
      void'($urandom(32'h6B48));
      repeat (6) @(posedge clk_i);
      #1 rst_i = 0;
      for (int i = 0; i < 6; i++) exp_q.push_back(RSC_VER_TEXT[8*(5-i) +: 8]);
      run("version", 8'h00, 8'h00, 8'h01, 1);
      frz = 1;
      host.slow = 1;
      repeat (4) begin
         sig_i = 16'($urandom);
         exp_q = '{hx(sig_i.env[7:4]), hx(sig_i.env[3:0]), hx(sig_i.data[7:4]), hx(sig_i.data[3:0])};
         run("signal", 8'h00, 8'h01, 8'h01, 1);
      end
      frz = 0;
      host.slow = 0;
      foreach (bad[i]) run("unknown", bad[i][23:16], bad[i][15:8], bad[i][7:0], 0);
      chk_n(n_def, 0);
      exp_q = '{RSC_CH_O, RSC_CH_K};
      run("defaults", 8'h80, 8'h21, 8'h01, 1);
      chk_n(n_def, 1);
      exp_q = '{RSC_CH_O, RSC_CH_K};
      n_tst = 0;
      run("reset", 8'h80, 8'h20, 8'h01, 1);
      chk_n(n_tst, int'(RSC_TEST_CYC));
      chk_b({7'h00, ready_o}, 8'h01);
      sig_i = 16'hA50F;
      exp_q = '{8'h41, 8'h35, 8'h30, 8'h46};
      run("after reset", 8'h00, 8'h01, 8'h01, 1);
      close_out();
   end
   initial begin
      #(100 * 30000);
      n_fail++;
      close_out();
   end
endmodule // testbench
`default_nettype wire

// ---- verilog/rsc_pkg.sv ----
// Purpose: constants and types for the radio module service-command handler
// Assumes: byte-wide command and reply streams on one 10 MHz clock
// Notes:   command codes are three-byte sequences; replies are ASCII bytes
`default_nettype none
package rsc_pkg;
   // ------------------------------------------------------------
   // command bytes
   // ------------------------------------------------------------
   localparam logic [7:0] RSC_HDR_QRY   = 8'h00;  // first byte of queries
   localparam logic [7:0] RSC_HDR_SVC   = 8'h80;  // first byte of service commands
   localparam logic [7:0] RSC_OP_VER    = 8'h00;  // version query second byte
   localparam logic [7:0] RSC_OP_SIG    = 8'h01;  // signal query second byte
   localparam logic [7:0] RSC_OP_RST    = 8'h20;  // soft reset second byte
   localparam logic [7:0] RSC_OP_DEF    = 8'h21;  // restore defaults second byte
   localparam logic [7:0] RSC_TAIL      = 8'h01;  // closing byte of every command
   // ------------------------------------------------------------
   // reply text
   // ------------------------------------------------------------
   localparam logic [7:0] RSC_CH_O      = 8'h4F;  // 'O'
   localparam logic [7:0] RSC_CH_K      = 8'h4B;  // 'K'
   localparam logic [7:0] RSC_CH_0      = 8'h30;  // '0'
   localparam logic [7:0] RSC_CH_A      = 8'h37;  // 'A' minus ten
   localparam int         RSC_VER_LEN   = 6;      // version text length
   // version text is arbitrary, not a real firmware name
   localparam logic [8*RSC_VER_LEN-1:0] RSC_VER_TEXT = 48'h76_31_2E_30_2E_30; // "v1.0.0"
   localparam logic [3:0] RSC_OK_LEN    = 4'h2;   // "OK"
   localparam logic [3:0] RSC_SIG_LEN   = 4'h4;   // four hex characters
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int         RSC_CLK_KHZ   = 10000;  // 10 MHz clock
   localparam int         RSC_TEST_US   = 100;    // self-test length in us
   localparam logic [15:0] RSC_TEST_CYC = 16'((RSC_TEST_US * RSC_CLK_KHZ) / 1000);
   localparam logic [15:0] RSC_ZERO16   = 16'h0000;
   localparam logic [3:0] RSC_ZERO4     = 4'h0;
   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0] env;   // environment strength
      logic [7:0] data;  // last received data strength
   } rsc_sig_t;
   typedef enum logic [2:0] {
      RSC_IDLE  = 3'b000,  // waiting for first byte
      RSC_GOT1  = 3'b001,  // first byte held
      RSC_GOT2  = 3'b011,  // second byte held
      RSC_REPLY = 3'b010,  // sending reply bytes
      RSC_TEST  = 3'b110,  // internal reset and self-test
      RSC_LOAD  = 3'b111   // reloading defaults
   } rsc_state_t;
   typedef enum logic [1:0] {
      RSC_R_VER = 2'h0,
      RSC_R_OK  = 2'h1,
      RSC_R_SIG = 2'h2
   } rsc_reply_t;
endpackage : rsc_pkg
`default_nettype wire

// ---- verilog/rsc_service.sv ----
// Purpose: decode service commands from the host and answer them
// Assumes: bytes arrive already deserialised, one per strobe, same clock
// Notes:   ready line is low while any command past its first byte is in hand
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - version query returns ASCII version text
// - reset command: send OK, then reset
// - ready low during reset self-test
// - ready high after self-test, resume work
// - restore defaults reloads settings, answers OK
// - signal query returns four hex characters
// - signal query needs no setup, accepted whenever idle
module rsc_service
   import rsc_pkg::*;
(
   input  wire logic       clk_i,         // 10 MHz clock
   input  wire logic       rst_i,         // synchronous reset, active high
   input  wire logic       ce_i,          // clock enable, freezes all state
   input  wire logic [7:0] rx_byte_i,     // received command byte
   input  wire logic       rx_valid_i,    // strobe with rx_byte_i
   input  var  rsc_sig_t   sig_i,         // live signal strengths
   input  wire logic       tx_ready_i,    // transmitter can take a byte
   output logic      [7:0] tx_byte_o,     // reply byte
   output logic            tx_valid_o,    // reply byte is offered
   output logic            ready_o,       // ready indicator, high when idle
   output logic            defaults_o,    // one-cycle pulse: reload defaults
   output logic            int_reset_o    // level: internal reset of logic
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   rsc_state_t state, next_state;          // decoder state
   logic [7:0] byte1, next_byte1;          // first command byte
   logic [7:0] byte2, next_byte2;          // second command byte
   rsc_reply_t kind, next_kind;            // reply in progress
   logic [3:0] idx, next_idx;              // reply byte index
   logic [3:0] len, next_len;              // reply length
   logic [15:0] cnt, next_cnt;             // self-test timer
   logic       post_rst, next_post_rst;    // reset follows the reply
   rsc_sig_t   snap, next_snap;            // strengths caught at the query
   logic [7:0] txb, next_txb;              // registered reply byte
   logic       txv, next_txv;              // registered reply valid
   logic       dflt, next_dflt;            // defaults pulse
   logic [7:0] reply_ch;                   // byte for current index

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // one nibble to an ASCII hex character
   function automatic logic [7:0] hex_ch(input logic [3:0] n);
      logic [7:0] base;
      base = (n > 4'h9) ? RSC_CH_A : RSC_CH_0;
      return base + {4'h0, n};
   endfunction

   // pick reply byte from index
   // the version index runs past the text once a reply ends; the byte
   // is only loaded while a reply is in hand, so that value never shows
   always_comb begin
      reply_ch = RSC_CH_O;
      case (kind)
         RSC_R_VER: begin
            // text is stored first character high
            reply_ch = RSC_VER_TEXT[8*(RSC_VER_LEN-1-int'(idx)) +: 8];
         end
         RSC_R_SIG: begin
            // environment first, then data, high nibble first
            case (idx[1:0])
               2'h0:    reply_ch = hex_ch(snap.env[7:4]);
               2'h1:    reply_ch = hex_ch(snap.env[3:0]);
               2'h2:    reply_ch = hex_ch(snap.data[7:4]);
               default: reply_ch = hex_ch(snap.data[3:0]);
            endcase
         end
         default: begin
            reply_ch = (idx == RSC_ZERO4) ? RSC_CH_O : RSC_CH_K;
         end
      endcase
   end

   // ------------------------------------------------------------
   // next-state logic
   // ------------------------------------------------------------
   always_comb begin
      next_state    = state;
      next_byte1    = byte1;
      next_byte2    = byte2;
      next_kind     = kind;
      next_idx      = idx;
      next_len      = len;
      next_cnt      = cnt;
      next_post_rst = post_rst;
      next_snap     = snap;
      next_txb      = txb;
      next_txv      = txv;
      next_dflt     = 1'b0;
      case (state)
         RSC_IDLE: begin
            // only known header bytes start a command
            if (rx_valid_i && (rx_byte_i == RSC_HDR_QRY || rx_byte_i == RSC_HDR_SVC)) begin
               next_byte1 = rx_byte_i;
               next_state = RSC_GOT1;
            end
         end
         RSC_GOT1: begin
            // any second byte is held; the tail byte decides if it counts
            if (rx_valid_i) begin
               next_byte2 = rx_byte_i;
               next_state = RSC_GOT2;
            end
         end
         RSC_GOT2: begin
            if (rx_valid_i) begin
               next_state = RSC_IDLE;   // unknown sequence dropped
               next_idx   = RSC_ZERO4;
               if (rx_byte_i == RSC_TAIL) begin
                  if (byte1 == RSC_HDR_QRY && byte2 == RSC_OP_VER) begin
                     next_kind  = RSC_R_VER;
                     next_len   = 4'(RSC_VER_LEN);
                     next_state = RSC_REPLY;
                  end else if (byte1 == RSC_HDR_QRY && byte2 == RSC_OP_SIG) begin
                     next_snap  = sig_i;              // caught as the tail byte arrives
                     next_kind  = RSC_R_SIG;
                     next_len   = RSC_SIG_LEN;
                     next_state = RSC_REPLY;
                  end else if (byte1 == RSC_HDR_SVC && byte2 == RSC_OP_RST) begin
                     next_kind     = RSC_R_OK;        // OK first, then reset
                     next_len      = RSC_OK_LEN;
                     next_post_rst = 1'b1;
                     next_state    = RSC_REPLY;
                  end else if (byte1 == RSC_HDR_SVC && byte2 == RSC_OP_DEF) begin
                     next_dflt  = 1'b1;               // reload factory settings
                     next_state = RSC_LOAD;
                  end
               end
            end
         end
         RSC_LOAD: begin
            // defaults take one cycle, then acknowledge
            next_kind  = RSC_R_OK;
            next_len   = RSC_OK_LEN;
            next_state = RSC_REPLY;
         end
         RSC_REPLY: begin
            if (!txv) begin
               next_txb = reply_ch;
               next_txv = 1'b1;
            end else if (tx_ready_i) begin
               next_txv = 1'b0;
               next_idx = idx + 4'h1;
               if (idx + 4'h1 == len) begin
                  // reply done; reset, if asked, only now
                  next_state = post_rst ? RSC_TEST : RSC_IDLE;
                  next_cnt   = RSC_ZERO16;
               end
            end
         end
         RSC_TEST: begin
            // self-test runs for a fixed time
            // bytes offered now are dropped, the host must wait for ready
            next_post_rst = 1'b0;
            next_cnt      = cnt + 16'h0001;
            if (cnt == RSC_TEST_CYC - 16'h0001) begin
               next_state = RSC_IDLE;   // resume normal work
            end
         end
         default: begin
            next_state = RSC_IDLE;
         end
      endcase
   end

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   // reset wins over the enable so a frozen block still comes up clean
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state    <= RSC_IDLE;
         byte1    <= 8'h00;
         byte2    <= 8'h00;
         kind     <= RSC_R_OK;
         idx      <= 4'h0;
         len      <= 4'h0;
         cnt      <= 16'h0000;
         post_rst <= 1'b0;
         snap     <= '0;
         txb      <= 8'h00;
         txv      <= 1'b0;
         dflt     <= 1'b0;
      end else if (ce_i) begin
         state    <= next_state;
         byte1    <= next_byte1;
         byte2    <= next_byte2;
         kind     <= next_kind;
         idx      <= next_idx;
         len      <= next_len;
         cnt      <= next_cnt;
         post_rst <= next_post_rst;
         snap     <= next_snap;
         txb      <= next_txb;
         txv      <= next_txv;
         dflt     <= next_dflt;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign tx_byte_o   = txb;
   assign tx_valid_o  = txv;
   assign defaults_o  = dflt;
   assign int_reset_o = (state == RSC_TEST);
   // low while a command is in hand or during self
   // ready stays high after a lone first byte: a partial command is not
   // yet accepted, and no timeout clears it, so following bytes finish it
   assign ready_o     = (state == RSC_IDLE) || (state == RSC_GOT1);
endmodule // rsc_service
`default_nettype wire
